// ### shared/fps_cfg.svh
/*
  Timing constants, field positions and register offsets for the flyback
  protection sequencer. Assumes a single 25 MHz system clock.
*/
// Function
// - peak setpoint at clamp starts the overload fault timer
// - fault timer expiry stops drive; latched or autorecovery protection by option
// - setpoint back below clamp before expiry clears the fault timer
// - pulse ended by maximum duty also starts the fault timer
// - autorecovery waits restart delay, restarts, repeats burst while fault stays
// - latched protection released only by brown-out or supply reset
// - overpower compensation current on only while feedback above its threshold
// - peak detector sampled then reset on brown-out comparator transitions
// - without line crossings a watchdog expiry makes the sample and reset events
// - frequency folds linearly toward minimum; jitter off during foldback
// - foldback inhibited while running at maximum duty
// - feedback at skip entry stops drive, low power until skip exit
// - skip exit resumes drive with a voltage-mode gentle restart ramp
// - feedback above foldback threshold ends the gentle ramp at once
// - switching allowed only inside latch window; either crossing latches off
// - latch crossings shorter than their blanking time are ignored
// - latch-input latch-off released only by brown-out or supply reset
// - latch input ignored until ready to start
// - high latch armed at turn-on, low latch after soft-start ends
// - thermistor bias current doubled during start-up soft-start
// - thermal shutdown stops switching, startup source off, logic reset
// - cooling below low threshold re-enables source and restarts normally
// - winding-short current level enters protection immediately
// - line below brown-out stop acts only after a persisting delay
// - line overvoltage comparator blanked for a fixed time
`ifndef FPS_CFG_SVH
`define FPS_CFG_SVH

`define FPS_CLK_MHZ         25
`define FPS_T_FAULT_US      128000
`define FPS_T_RESTART_US    1000000
`define FPS_T_SSTART_US     4000
`define FPS_T_GENTLE_US     300
`define FPS_T_WATCHDOG_US   30000
`define FPS_T_BROWNOUT_US   60000
`define FPS_T_OVBLANK_US    10
`define FPS_T_HIBLANK_US    10
`define FPS_T_LOBLANK_US    10
`define FPS_US2CYC(us)      ((us) * `FPS_CLK_MHZ)

`define FPS_FREQ_NOM        8'hff
`define FPS_FREQ_MIN        8'h40
`define FPS_SKIP_IN_CODE    8'h20

`define FPS_ADDR_CTRL       12'h000
`define FPS_ADDR_STATUS     12'h004
`define FPS_CTRL_LATCHED    0
`define FPS_CTRL_DC_LINE    1
`define FPS_CTRL_RESET      32'h0000_0000

`endif

// ### shared/fps_pkg.sv
/*
  Types for the flyback protection sequencer: comparator bundle, output
  bundle and the controller state encoding. Assumes fps_cfg.svh alongside.
*/
package fps_pkg;

  typedef struct packed {
    logic cs_at_clamp;      // setpoint at peak_current_clamp
    logic cs_winding_short; // current sense above 1.5x clamp
    logic max_duty_term;    // last pulse ended by max duty
    logic fb_below_skip_in; // feedback at skip entry
    logic fb_above_skip_out;
    logic fb_above_fold;    // feedback above foldback_threshold
    logic fb_above_opc;     // feedback above overpower_comp_threshold
    logic line_below_stop;  // brown-out comparator
    logic line_above_start;
    logic line_over;        // line overvoltage comparator
    logic latch_high;       // latch input above high threshold
    logic latch_low;        // latch input below low threshold
    logic thermal_hot;      // thermal_shutdown high threshold
    logic thermal_cool;     // below low threshold
    logic supply_on;        // supply_turn_on_threshold reached
    logic supply_reset;     // supply at supply_reset_threshold
  } fps_comp_t;

  typedef struct packed {
    logic       gate_drive_out;
    logic       hv_source_en;
    logic       overpower_comp_current;
    logic       peak_sample;
    logic       peak_reset;
    logic       fold_active;
    logic       jitter_en;
    logic       skip_low_power;
    logic       gentle_ramp_active;
    logic       thermistor_bias_double;
    logic [7:0] osc_freq_code;
    logic [7:0] ramp_level;
  } fps_ctl_t;

  typedef enum logic [6:0] {
    FPS_OFF     = 7'b000_0001,
    FPS_SSTART  = 7'b000_0010,
    FPS_RUN     = 7'b000_0100,
    FPS_SKIP    = 7'b000_1000,
    FPS_AUTOREC = 7'b001_0000,
    FPS_LATCHED = 7'b010_0000,
    FPS_THERMAL = 7'b100_0000
  } fps_state_t;

endpackage

// ### rtl/fps_sequencer.sv
/*
  Supervisory sequencer of a current-mode flyback controller: protection,
  skip and foldback sequencing, latch input, thermal recovery, APB registers.
  Assumes analog comparators drive comp asynchronously and fb_code comes from
  a converter already on pclk.
*/
// Implementation choices: register access over APB and the register addresses.
`timescale 1ns/1ns
`include "fps_cfg.svh"

module fps_sequencer #(
  parameter int unsigned T_FAULT    = `FPS_US2CYC(`FPS_T_FAULT_US),
  parameter int unsigned T_RESTART  = `FPS_US2CYC(`FPS_T_RESTART_US),
  parameter int unsigned T_SSTART   = `FPS_US2CYC(`FPS_T_SSTART_US),
  parameter int unsigned T_GENTLE   = `FPS_US2CYC(`FPS_T_GENTLE_US),
  parameter int unsigned T_WATCHDOG = `FPS_US2CYC(`FPS_T_WATCHDOG_US),
  parameter int unsigned T_BROWNOUT = `FPS_US2CYC(`FPS_T_BROWNOUT_US),
  parameter int unsigned T_OVBLANK  = `FPS_US2CYC(`FPS_T_OVBLANK_US),
  parameter int unsigned T_HIBLANK  = `FPS_US2CYC(`FPS_T_HIBLANK_US),
  parameter int unsigned T_LOBLANK  = `FPS_US2CYC(`FPS_T_LOBLANK_US)
) (
  input  wire logic             pclk,     // system clock, 25 MHz
  input  wire logic             presetn,  // async reset, active low
  input  wire logic             psel,     // apb select
  input  wire logic             penable,  // apb access phase
  input  wire logic             pwrite,   // apb direction
  input  wire logic [11:0]      paddr,    // apb byte address
  input  wire logic [31:0]      pwdata,   // apb write data
  output logic      [31:0]      prdata,   // apb read data
  output logic                  pready,   // apb ready
  output logic                  pslverr,  // apb error on unmapped address
  input  wire fps_pkg::fps_comp_t comp,   // raw comparator levels
  input  wire logic [7:0]       fb_code,  // digitised feedback level
  output fps_pkg::fps_ctl_t     ctl       // registered control outputs
);
  import fps_pkg::*;

  // ---------------------------------------------------------------
  // input synchronisers
  // ---------------------------------------------------------------
  localparam int NC = $bits(fps_comp_t);
  logic [NC-1:0] sync_meta;
  logic [NC-1:0] sync_q;
  fps_comp_t     c;

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      sync_meta <= '0;
      sync_q    <= '0;
    end
    else
    begin
      sync_meta <= comp;
      sync_q    <= sync_meta;
    end
  end
  assign c = fps_comp_t'(sync_q);

  // ---------------------------------------------------------------
  // apb slave
  // ---------------------------------------------------------------
  logic [31:0] ctrl;
  fps_state_t  state;
  logic        latch_fault;
  logic        brownout;
  logic        line_ov;
  logic        fault_seen;

  function automatic logic addr_ok(input logic [11:0] a);
    addr_ok = (a == `FPS_ADDR_CTRL) || (a == `FPS_ADDR_STATUS);
  endfunction

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= 32'h0000_0000;
    end
    else
    begin
      // zero wait states: ready rises in the access cycle after setup
      pready  <= psel && !penable;
      pslverr <= psel && !penable && !addr_ok(paddr);
      if (psel && !penable && !pwrite && paddr == `FPS_ADDR_CTRL)
        prdata <= ctrl;
      else if (psel && !penable && !pwrite && paddr == `FPS_ADDR_STATUS)
        prdata <= {21'h00_0000, fault_seen, line_ov, brownout, latch_fault, state};
      else
        prdata <= 32'h0000_0000;
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      ctrl <= `FPS_CTRL_RESET;
    else if (psel && penable && pready && pwrite && paddr == `FPS_ADDR_CTRL)
      ctrl <= {30'h0000_0000, pwdata[`FPS_CTRL_DC_LINE], pwdata[`FPS_CTRL_LATCHED]};
  end

  wire opt_latched = ctrl[`FPS_CTRL_LATCHED];
  wire dc_line     = ctrl[`FPS_CTRL_DC_LINE];

  // ---------------------------------------------------------------
  // persistence filters: high latch, low latch, brown-out, line ov
  // ---------------------------------------------------------------
  function automatic int unsigned filt_len(input int i);
    case (i)
      0:       filt_len = T_HIBLANK;
      1:       filt_len = T_LOBLANK;
      2:       filt_len = T_BROWNOUT;
      default: filt_len = T_OVBLANK;
    endcase
  endfunction

  logic [3:0] filt_in;
  logic [3:0] filt_out;
  wire        tsd_rst = c.thermal_hot || c.supply_reset;
  wire        hi_armed = state inside {FPS_SSTART, FPS_RUN, FPS_SKIP};
  wire        lo_armed = state inside {FPS_RUN, FPS_SKIP};

  assign filt_in = {c.line_over, c.line_below_stop,
                    c.latch_low && lo_armed, c.latch_high && hi_armed};

  for (genvar i = 0; i < 4; i++)
  begin : g_filt
    logic [31:0] cnt;
    always_ff @(posedge pclk or negedge presetn)
    begin
      if (!presetn)
        cnt <= 32'h0000_0000;
      else if (!filt_in[i] || tsd_rst)
        cnt <= 32'h0000_0000;
      else if (cnt < filt_len(i))
        cnt <= cnt + 32'h0000_0001;
    end
    assign filt_out[i] = (cnt >= filt_len(i));
  end

  // brown-out: set after persisting drop, cleared once line is back above start
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      brownout <= 1'b0;
    else if (filt_out[2])
      brownout <= 1'b1;
    else if (c.line_above_start)
      brownout <= 1'b0;
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      line_ov <= 1'b0;
    else
      line_ov <= filt_out[3];
  end

  // latch window violation is sticky until brown-out or supply reset
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      latch_fault <= 1'b0;
    else if (filt_out[0] || filt_out[1])
      latch_fault <= 1'b1;
    else if (brownout || c.supply_reset)
      latch_fault <= 1'b0;
  end

  // ---------------------------------------------------------------
  // overload fault timer
  // ---------------------------------------------------------------
  logic [31:0] fault_cnt;
  wire         overload = c.cs_at_clamp || c.max_duty_term;
  wire         fault_expired = (fault_cnt >= T_FAULT);

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      fault_cnt <= 32'h0000_0000;
    else if (!overload || state != FPS_RUN)
      fault_cnt <= 32'h0000_0000;
    else if (!fault_expired)
      fault_cnt <= fault_cnt + 32'h0000_0001;
  end

  wire protect = (state == FPS_RUN || state == FPS_SSTART) &&
                 (fault_expired || c.cs_winding_short);

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      fault_seen <= 1'b0;
    else if (protect)
      fault_seen <= 1'b1;
    else if (state == FPS_RUN && !overload)
      fault_seen <= 1'b0;
  end

  // ---------------------------------------------------------------
  // controller state machine
  // ---------------------------------------------------------------
  logic [31:0] st_cnt;
  fps_state_t  next_state;
  logic        ramp_on;
  wire         line_ok = !brownout && !line_ov;
  wire         sstart_done = (st_cnt >= T_SSTART);

  always_comb
  begin
    next_state = state;
    case (state)
      FPS_OFF:
        if (c.supply_on && line_ok && !latch_fault)
          next_state = FPS_SSTART;
      FPS_SSTART:
        if (protect)
          next_state = opt_latched ? FPS_LATCHED : FPS_AUTOREC;
        else if (!line_ok || latch_fault)
          next_state = latch_fault ? FPS_LATCHED : FPS_OFF;
        else if (sstart_done)
          next_state = FPS_RUN;
      FPS_RUN:
        if (protect)
          next_state = opt_latched ? FPS_LATCHED : FPS_AUTOREC;
        else if (latch_fault)
          next_state = FPS_LATCHED;
        else if (!line_ok)
          next_state = FPS_OFF;
        else if (c.fb_below_skip_in)
          next_state = FPS_SKIP;
      FPS_SKIP:
        if (latch_fault)
          next_state = FPS_LATCHED;
        else if (!line_ok)
          next_state = FPS_OFF;
        else if (c.fb_above_skip_out)
          next_state = FPS_RUN;
      FPS_AUTOREC:
        if (st_cnt >= T_RESTART)
          next_state = FPS_OFF;
      FPS_LATCHED:
        if ((brownout || c.supply_reset) && !latch_fault)
          next_state = FPS_OFF;
      FPS_THERMAL:
        if (c.thermal_cool)
          next_state = FPS_OFF;
      default:
        next_state = FPS_OFF;
    endcase
    // thermal overrides everything; supply reset, unless in thermal, forces the state back to off
    if (c.thermal_hot)
      next_state = FPS_THERMAL;
    else if (c.supply_reset && state != FPS_THERMAL)
      next_state = FPS_OFF;
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      state <= FPS_OFF;
    else
      state <= next_state;
  end

  // one timer serves soft-start, restart delay and gentle ramp
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      st_cnt <= 32'h0000_0000;
    else if (next_state != state)
      st_cnt <= 32'h0000_0000;
    else if (st_cnt != 32'hffff_ffff)
      st_cnt <= st_cnt + 32'h0000_0001;
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      ramp_on <= 1'b0;
    else if (state == FPS_SKIP && next_state == FPS_RUN)
      ramp_on <= 1'b1;
    else if (state != FPS_RUN || c.fb_above_fold || st_cnt >= T_GENTLE)
      ramp_on <= 1'b0;
  end

  // ---------------------------------------------------------------
  // peak detector sample and reset events
  // ---------------------------------------------------------------
  logic        bo_prev;
  logic [31:0] wd_cnt;
  logic        sample_q;
  wire         bo_edge = (c.line_below_stop != bo_prev) && !dc_line;
  wire         wd_exp = (wd_cnt >= T_WATCHDOG);
  wire         sample_ev = bo_edge || wd_exp;

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      bo_prev <= 1'b0;
      wd_cnt  <= 32'h0000_0000;
    end
    else
    begin
      bo_prev <= c.line_below_stop;
      if (sample_ev)
        wd_cnt <= 32'h0000_0000;
      else
        wd_cnt <= wd_cnt + 32'h0000_0001;
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      sample_q <= 1'b0;
    else
      sample_q <= sample_ev;
  end

  // ---------------------------------------------------------------
  // registered outputs
  // ---------------------------------------------------------------
  wire       running = (state == FPS_RUN || state == FPS_SSTART);
  wire       folding = (state == FPS_RUN) && !c.fb_above_fold && !c.max_duty_term;
  wire [7:0] fb_ofs  = (fb_code > `FPS_SKIP_IN_CODE) ? fb_code - `FPS_SKIP_IN_CODE : 8'h00;
  wire [8:0] fold_sum = {1'b0, `FPS_FREQ_MIN} + {1'b0, fb_ofs};
  wire [7:0] fold_freq = (fold_sum > {1'b0, `FPS_FREQ_NOM}) ? `FPS_FREQ_NOM : fold_sum[7:0];
  wire [7:0] ramp_lvl = (st_cnt >= T_GENTLE) ? 8'hff : 8'((st_cnt * 256) / T_GENTLE);

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      ctl <= '0;
    else
    begin
      ctl.gate_drive_out         <= running && !c.thermal_hot;
      ctl.hv_source_en           <= (state != FPS_THERMAL) && !c.thermal_hot;
      ctl.overpower_comp_current <= running && c.fb_above_opc;
      ctl.peak_sample            <= sample_ev;
      ctl.peak_reset             <= sample_q;
      ctl.fold_active            <= folding;
      ctl.jitter_en              <= running && !folding;
      ctl.skip_low_power         <= (state == FPS_SKIP);
      ctl.gentle_ramp_active     <= ramp_on;
      ctl.thermistor_bias_double <= (state == FPS_SSTART);
      ctl.osc_freq_code          <= folding ? fold_freq : `FPS_FREQ_NOM;
      ctl.ramp_level             <= ramp_on ? ramp_lvl : 8'hff;
    end
  end

endmodule

// ### verification/fps_sense_model.sv
/*
  Sense comparator and gate model facing the flyback sequencer.
  Assumes the bench sets the feedback level and the other comparator levels.
*/
`timescale 1ns/1ns
`include "fps_cfg.svh"

module fps_sense_model #(
  parameter logic [7:0] SKIP_OUT = 8'h30,
  parameter logic [7:0] FOLD     = 8'h80,
  parameter logic [7:0] OPC      = 8'hc0,
  parameter logic [7:0] CLAMP    = 8'hf0
) (
  input  wire logic               gate,    // gate drive from the sequencer
  input  wire logic [7:0]         fb_lvl,  // feedback level set by the bench
  input  wire fps_pkg::fps_comp_t misc,    // line, latch, thermal, supply levels
  output fps_pkg::fps_comp_t      comp,    // comparator levels to the sequencer
  output logic [7:0]              fb_code  // digitised feedback
);
  import fps_pkg::*;
  // ----------------------------------------
  // comparators
  // ----------------------------------------
  // clamp trips only while pulses run: no switch current with the gate off
  always_comb
  begin
    comp                   = misc;
    comp.cs_at_clamp       = misc.cs_at_clamp | (gate & (fb_lvl >= CLAMP));
    comp.fb_below_skip_in  = fb_lvl < `FPS_SKIP_IN_CODE;
    comp.fb_above_skip_out = fb_lvl > SKIP_OUT;
    comp.fb_above_fold     = fb_lvl > FOLD;
    comp.fb_above_opc      = fb_lvl > OPC;
  end
  assign fb_code = fb_lvl;
endmodule

// ### verification/fps_sequencer_props.sv
/*
  Port checker for the flyback sequencer, bound to its top module.
  Assumes one clock domain and comparator latency of a few cycles.
*/
`timescale 1ns/1ns

module fps_sequencer_props (
  input  wire logic               pclk,     // system clock
  input  wire logic               presetn,  // async reset, active low
  input  wire logic               psel,     // apb select
  input  wire logic               penable,  // apb access phase
  input  wire logic [11:0]        paddr,    // apb byte address
  input  wire logic               pready,   // apb ready
  input  wire logic               pslverr,  // apb error
  input  wire fps_pkg::fps_comp_t comp,     // comparator levels
  input  wire fps_pkg::fps_ctl_t  ctl       // control outputs
);
  import fps_pkg::*;
  // ----------------------------------------
  // properties
  // ----------------------------------------
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  apb_ready_a: assert property (psel && !penable |=> pready)
    else $error("no ready after setup");
  apb_unmapped_a: assert property (psel && !penable && !(paddr inside {12'h000, 12'h004}) |=> pslverr)
    else $error("no error on unmapped address");
  thermal_stop_a: assert property (comp.thermal_hot [*5] |-> !ctl.gate_drive_out && !ctl.hv_source_en)
    else $error("drive or source on while hot");
  opc_off_a: assert property (!comp.fb_above_opc [*5] |-> !ctl.overpower_comp_current)
    else $error("compensation on at low feedback");
  peak_pair_a: assert property (ctl.peak_sample |=> ctl.peak_reset)
    else $error("sample not followed by reset");
  skip_quiet_a: assert property (ctl.skip_low_power |-> !ctl.gate_drive_out)
    else $error("drive during skip");
  fold_maxduty_a: assert property (comp.max_duty_term [*5] |-> !ctl.fold_active)
    else $error("foldback at max duty");
  fold_jitter_a: assert property (ctl.fold_active |-> !ctl.jitter_en)
    else $error("jitter during foldback");
  ramp_end_a: assert property (comp.fb_above_fold [*7] |-> !ctl.gentle_ramp_active)
    else $error("ramp kept above foldback level");
  short_stop_a: assert property ($rose(comp.cs_winding_short) ##1 comp.cs_winding_short [*4]
    |=> !ctl.gate_drive_out)
    else $error("drive after winding short");

  cover property (ctl.peak_sample);
  cover property (ctl.skip_low_power ##1 !ctl.skip_low_power);
  cover property (ctl.gentle_ramp_active);
endmodule

bind fps_sequencer fps_sequencer_props chk_u (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
  .paddr(paddr), .pready(pready), .pslverr(pslverr), .comp(comp), .ctl(ctl));

// ### verification/fps_sequencer_bench.sv
/*
  Self-checking bench for the flyback sequencer with a comparator model.
  Assumes shortened delay parameters and a 25 MHz clock.
*/
`timescale 1ns/1ns
`define CHK(g, e) begin checks_done++; if ((g) !== (e)) begin num_errors++; \
  $display("[ERR] %0t mismatch got %0h exp %0h", $time, (g), (e)); end end

module fps_sequencer_bench;
  import fps_pkg::*;
  localparam int TF = 50, TR = 100, TS = 40, TW = 200, TB = 30;
  logic        pclk;
  logic        presetn = 1'b0;
  logic        psel    = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite  = 1'b0;
  logic [11:0] paddr   = 12'h000;
  logic [31:0] pwdata  = 32'h0;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  fps_comp_t   comp;
  fps_comp_t   misc    = '0;
  fps_ctl_t    ctl;
  logic [7:0]  fb_code;
  logic [7:0]  fb_lvl  = 8'h90;
  logic [7:0]  v;
  logic [31:0] rdat;
  logic        rerr;
  logic [31:0] cq[$]   = '{32'hffff_ffff, 32'h1, 32'h2, 32'h0};
  int          num_errors = 0;
  int          checks_done = 0;
  int          n_samp = 0;
  int          n0;

  fps_sequencer #(.T_FAULT(TF), .T_RESTART(TR), .T_SSTART(TS), .T_GENTLE(20), .T_WATCHDOG(TW),
    .T_BROWNOUT(TB), .T_OVBLANK(5), .T_HIBLANK(5), .T_LOBLANK(5)) dut_u (.pclk(pclk), .presetn(presetn),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .comp(comp), .fb_code(fb_code), .ctl(ctl));
  fps_sense_model partner_u (.gate(ctl.gate_drive_out), .fb_lvl(fb_lvl), .misc(misc), .comp(comp),
    .fb_code(fb_code));

  // ----------------------------------------
  // helpers
  // ----------------------------------------
  initial
  begin
    pclk = 1'b0;
    forever #20 pclk = ~pclk;
  end

  always @(posedge pclk)
    if (ctl.peak_sample === 1'b1) n_samp++;

  task automatic tally_and_finish;
    $display("checks %0d errors %0d", checks_done, num_errors);
    if (num_errors == 0 && checks_done > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask

  task automatic wt(input int n);
    repeat (n) @(posedge pclk);
  endtask

  // one apb transfer; a gap cycle after it keeps strobes single-driven
  task automatic bus(input logic wr, input logic [11:0] a, input logic [31:0] d);
    psel    <= 1'b1;
    pwrite  <= wr;
    paddr   <= a;
    pwdata  <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    // no cycle count assumed: only the watchdog ends a stuck wait
    while (pready !== 1'b1)
      @(posedge pclk);
    rdat = prdata;
    rerr = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask

  task automatic st(input logic [6:0] e);
    bus(1'b0, 12'h004, 32'h0);
    `CHK(rdat[6:0], e)
  endtask

  initial
  begin
    wt(5000);
    num_errors++;
    tally_and_finish;
  end

  // ----------------------------------------
  // tests
  // ----------------------------------------
  initial
  begin
    void'($urandom(32'h95fb));
    wt(2);
    presetn <= 1'b1;
    @(posedge pclk);
    st(7'h01);
    bus(1'b0, 12'h008, 32'h0);
    `CHK(rerr, 1'b1)
    foreach (cq[i])
    begin
      bus(1'b1, 12'h000, cq[i]);
      bus(1'b0, 12'h000, 32'h0);
      `CHK(rdat, cq[i] & 32'h3)
    end
    bus(1'b1, 12'h004, 32'hffff_ffff);
    `CHK(rerr, 1'b0)
    $display("test registers done");
    misc.supply_on <= 1'b1;
    misc.line_above_start <= 1'b1;
    wt(8);
    st(7'h02);
    `CHK(ctl.thermistor_bias_double, 1'b1)
    misc.latch_low <= 1'b1;
    wt(15);
    misc.latch_low <= 1'b0;
    wt(25);
    st(7'h04);
    `CHK(rdat[7], 1'b0)
    `CHK(ctl.thermistor_bias_double, 1'b0)
    $display("test startup done");
    repeat (6)
    begin
      v = 8'h31 + 8'($urandom % 79);
      fb_lvl <= v;
      wt(6);
      `CHK(ctl.fold_active, 1'b1)
      `CHK(ctl.osc_freq_code, v + 8'h20)
    end
    misc.max_duty_term <= 1'b1;
    wt(6);
    `CHK(ctl.osc_freq_code, 8'hff)
    misc.max_duty_term <= 1'b0;
    fb_lvl <= 8'h90;
    wt(6);
    `CHK(ctl.jitter_en, 1'b1)
    `CHK(ctl.overpower_comp_current, 1'b0)
    fb_lvl <= 8'hd0;
    wt(6);
    `CHK(ctl.overpower_comp_current, 1'b1)
    $display("test foldback done");
    fb_lvl <= 8'h10;
    wt(6);
    st(7'h08);
    `CHK(ctl.skip_low_power, 1'b1)
    fb_lvl <= 8'h28;
    wt(6);
    st(7'h08);
    fb_lvl <= 8'h40;
    wt(6);
    `CHK(ctl.gentle_ramp_active, 1'b1)
    `CHK(ctl.gate_drive_out, 1'b1)
    fb_lvl <= 8'h90;
    wt(5);
    `CHK(ctl.gentle_ramp_active, 1'b0)
    `CHK(ctl.ramp_level, 8'hff)
    $display("test skip done");
    fb_lvl <= 8'hf8;
    wt(30);
    fb_lvl <= 8'h90;
    wt(40);
    st(7'h04);
    fb_lvl <= 8'hf8;
    wt(TF + 6);
    st(7'h10);
    `CHK(ctl.gate_drive_out, 1'b0)
    wt(TR);
    st(7'h02);
    wt(TS + TF + 10);
    st(7'h10);
    fb_lvl <= 8'h90;
    bus(1'b1, 12'h000, 32'h1);
    wt(TR + TS + 10);
    misc.max_duty_term <= 1'b1;
    wt(TF + 8);
    st(7'h20);
    misc.max_duty_term <= 1'b0;
    wt(TR + 20);
    st(7'h20);
    misc.supply_reset <= 1'b1;
    wt(4);
    misc.supply_reset <= 1'b0;
    wt(8);
    st(7'h02);
    wt(TS + 6);
    $display("test overload done");
    misc.latch_high <= 1'b1;
    wt(3);
    misc.latch_high <= 1'b0;
    wt(8);
    st(7'h04);
    misc.latch_high <= 1'b1;
    wt(15);
    misc.latch_high <= 1'b0;
    wt(40);
    st(7'h20);
    `CHK(rdat[7], 1'b1)
    misc.line_below_stop <= 1'b1;
    misc.line_above_start <= 1'b0;
    wt(TB + 8);
    bus(1'b0, 12'h004, 32'h0);
    `CHK(rdat[8:7], 2'b10)
    misc.line_below_stop <= 1'b0;
    misc.line_above_start <= 1'b1;
    wt(TS + 12);
    n0 = n_samp;
    misc.line_below_stop <= 1'b1;
    wt(10);
    misc.line_below_stop <= 1'b0;
    wt(10);
    st(7'h04);
    `CHK(n_samp - n0, 2)
    bus(1'b1, 12'h000, 32'h2);
    n0 = n_samp;
    wt(TW + 10);
    `CHK(n_samp - n0, 1)
    $display("test latch and line done");
    misc.line_over <= 1'b1;
    wt(3);
    misc.line_over <= 1'b0;
    wt(8);
    st(7'h04);
    misc.thermal_hot <= 1'b1;
    wt(6);
    st(7'h40);
    `CHK(ctl.hv_source_en, 1'b0)
    misc.thermal_hot <= 1'b0;
    misc.thermal_cool <= 1'b1;
    wt(6);
    st(7'h02);
    `CHK(ctl.hv_source_en, 1'b1)
    wt(TS + 6);
    misc.cs_winding_short <= 1'b1;
    wt(6);
    st(7'h10);
    $display("test thermal and short done");
    tally_and_finish;
  end
endmodule
